// file: hdl/bcr_pkg.sv
// Package: register map, field layout and reset values for converter control
package bcr_pkg;
  localparam int unsigned BCR_NUM_CONV = 3;
  localparam logic [7:0] BCR_OFS_CONV_A = 8'h25;
  localparam logic [7:0] BCR_OFS_CONV_B = 8'h26;
  localparam logic [7:0] BCR_OFS_CONV_C = 8'h27;
  localparam logic [7:0] BCR_CTRL_RESET = 8'h0d;
  localparam logic [7:0] BCR_CTRL_WMASK = 8'h3f;
  localparam int unsigned BCR_SLP_LSB = 4;
  localparam int unsigned BCR_RSV_LSB = 2;
  localparam int unsigned BCR_MODE_BIT = 1;
  localparam int unsigned BCR_EN_BIT = 0;
  localparam logic [1:0] BCR_SLP_OFF = 2'h0;
  localparam logic [1:0] BCR_RSV_OK = 2'h3;
  localparam logic [7:0] BCR_READ_UNMAPPED = 8'h00;
  localparam logic [6:0] BCR_VID_RESET = 7'h00;
  typedef enum logic {BCR_MODE_AUTO, BCR_MODE_FPWM} bcr_mode_e;
endpackage

// file: hdl/bcr_conv_if.sv
// Interface: per-converter register fields and regulation controls
`timescale 1ns/100ps
interface bcr_conv_if;
  logic [7:0] ctrl;
  logic pins_on;
  logic sleep_req;
  logic [6:0] norm_vid;
  logic [6:0] sleep_vid;
  logic conv_on;
  logic fpwm;
  logic in_sleep;
  logic vid_valid;
  logic [6:0] active_vid;
  modport regs (output ctrl, pins_on, sleep_req, norm_vid, sleep_vid,
    input conv_on, fpwm, in_sleep, vid_valid, active_vid);
  modport conv (input ctrl, pins_on, sleep_req, norm_vid, sleep_vid,
    output conv_on, fpwm, in_sleep, vid_valid, active_vid);
endinterface

// file: hdl/bcr_conv.sv
// Per-converter control: enable, mode, sleep entry and voltage code
`timescale 1ns/100ps
module bcr_conv (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Fields
  bcr_conv_if.conv cif
);
  import bcr_pkg::*;

  typedef struct packed {
    logic in_sleep;
    logic [6:0] active_vid;
  } bcr_conv_s;

  bcr_conv_s st;
  bcr_conv_s next_st;
  logic slp_en;

  always_comb begin
    slp_en = cif.ctrl[BCR_SLP_LSB +: 2] != BCR_SLP_OFF;
    next_st = st;
    next_st.in_sleep = slp_en && cif.sleep_req;
    if (next_st.in_sleep && !st.in_sleep) begin
      next_st.active_vid = cif.sleep_vid;
    end else if (!next_st.in_sleep) begin
      next_st.active_vid = cif.norm_vid;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st <= '{in_sleep: 1'b0, active_vid: BCR_VID_RESET};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign cif.in_sleep = st.in_sleep;
  assign cif.active_vid = st.active_vid;
  // Register bit forces off, else pins decide
  assign cif.conv_on = cif.ctrl[BCR_EN_BIT] && cif.pins_on;
  assign cif.fpwm = cif.ctrl[BCR_MODE_BIT] == BCR_MODE_FPWM;
  assign cif.vid_valid = cif.ctrl[BCR_RSV_LSB +: 2] == BCR_RSV_OK;

  sleep_copy_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    i_ce && slp_en && cif.sleep_req && !st.in_sleep
    |=> st.in_sleep && st.active_vid == $past(cif.sleep_vid))
    else $error("sleep code not copied on entry");
  sleep_gate_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    i_ce && !slp_en |=> !st.in_sleep)
    else $error("sleep entered while disabled");
endmodule

// file: hdl/bcr_regs.sv
// Top: control register bank for three step-down converters
`timescale 1ns/100ps
module bcr_regs (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Register access from serial bus front end
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Sequencing and sleep pins
  input wire logic [bcr_pkg::BCR_NUM_CONV-1:0] i_pins_on,
  input wire logic [bcr_pkg::BCR_NUM_CONV-1:0] i_sleep_req,
  input wire logic [bcr_pkg::BCR_NUM_CONV*7-1:0] i_norm_vid,
  input wire logic [bcr_pkg::BCR_NUM_CONV*7-1:0] i_sleep_vid,
  // Converter controls
  output logic [bcr_pkg::BCR_NUM_CONV-1:0] o_conv_on,
  output logic [bcr_pkg::BCR_NUM_CONV-1:0] o_fpwm,
  output logic [bcr_pkg::BCR_NUM_CONV-1:0] o_in_sleep,
  output logic [bcr_pkg::BCR_NUM_CONV-1:0] o_vid_valid,
  output logic [bcr_pkg::BCR_NUM_CONV*7-1:0] o_active_vid
);
  import bcr_pkg::*;

  typedef struct packed {
    logic [BCR_NUM_CONV-1:0][7:0] ctrl;
    logic [7:0] rdata;
  } bcr_regs_s;

  bcr_regs_s st;
  bcr_regs_s next_st;
  logic [BCR_NUM_CONV-1:0] hit;

  // --------------------------------------------------------------
  // Address decode and register update
  // --------------------------------------------------------------
  always_comb begin
    hit[0] = i_addr == BCR_OFS_CONV_A;
    hit[1] = i_addr == BCR_OFS_CONV_B;
    hit[2] = i_addr == BCR_OFS_CONV_C;
    next_st = st;
    for (int i = 0; i < BCR_NUM_CONV; i++) begin
      if (i_wr && hit[i]) begin
        next_st.ctrl[i] = i_wdata & BCR_CTRL_WMASK;
      end
    end
    if (i_rd) begin
      next_st.rdata = BCR_READ_UNMAPPED;
      for (int i = 0; i < BCR_NUM_CONV; i++) begin
        if (hit[i]) begin
          next_st.rdata = st.ctrl[i] & BCR_CTRL_WMASK;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st.ctrl <= {BCR_NUM_CONV{BCR_CTRL_RESET}};
      st.rdata <= BCR_READ_UNMAPPED;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;

  // --------------------------------------------------------------
  // Per-converter control
  // --------------------------------------------------------------
  for (genvar g = 0; g < BCR_NUM_CONV; g++) begin : g_conv
    bcr_conv_if cif ();
    assign cif.ctrl = st.ctrl[g];
    assign cif.pins_on = i_pins_on[g];
    assign cif.sleep_req = i_sleep_req[g];
    assign cif.norm_vid = i_norm_vid[g*7 +: 7];
    assign cif.sleep_vid = i_sleep_vid[g*7 +: 7];
    assign o_conv_on[g] = cif.conv_on;
    assign o_fpwm[g] = cif.fpwm;
    assign o_in_sleep[g] = cif.in_sleep;
    assign o_vid_valid[g] = cif.vid_valid;
    assign o_active_vid[g*7 +: 7] = cif.active_vid;
    bcr_conv u_conv (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .cif(cif)
    );

    force_off_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && i_wr && hit[g] && !i_wdata[BCR_EN_BIT] |=> !o_conv_on[g])
      else $error("converter not forced off");

    pins_follow_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      st.ctrl[g][BCR_EN_BIT] |-> o_conv_on[g] == i_pins_on[g])
      else $error("enable does not follow pins");

    mode_sel_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && i_wr && hit[g] |=> o_fpwm[g] == $past(i_wdata[BCR_MODE_BIT]))
      else $error("mode bit not applied");

    code_gate_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && i_wr && hit[g] && i_wdata[BCR_RSV_LSB +: 2] != BCR_RSV_OK |=> !o_vid_valid[g])
      else $error("codes valid with bad reserved field");
  end

  // --------------------------------------------------------------
  // Per-converter register and sleep checks
  // --------------------------------------------------------------
  for (genvar g = 0; g < BCR_NUM_CONV; g++) begin : g_chk
    wr_lands_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && i_wr && hit[g] |=> st.ctrl[g] == ($past(i_wdata) & BCR_CTRL_WMASK))
      else $error("write did not land");

    top_zero_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      (st.ctrl[g] & ~BCR_CTRL_WMASK) == 8'h00)
      else $error("top bits stored nonzero");

    no_hit_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && !(i_wr && hit[g]) |=> $stable(st.ctrl[g]))
      else $error("register changed without a write");

    ce_freeze_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      !i_ce |=> $stable(st.ctrl[g]))
      else $error("register changed while frozen");

    en_off_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      !st.ctrl[g][BCR_EN_BIT] |-> !o_conv_on[g])
      else $error("converter on with enable bit clear");

    mode_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      o_fpwm[g] == st.ctrl[g][BCR_MODE_BIT])
      else $error("mode output differs from register");

    valid_rsv_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      o_vid_valid[g] == (st.ctrl[g][BCR_RSV_LSB +: 2] == BCR_RSV_OK))
      else $error("code valid differs from reserved field");

    sleep_off_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && st.ctrl[g][BCR_SLP_LSB +: 2] == BCR_SLP_OFF |=> !o_in_sleep[g])
      else $error("sleep with sleep field off");

    sleep_on_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && st.ctrl[g][BCR_SLP_LSB +: 2] != BCR_SLP_OFF && i_sleep_req[g] |=> o_in_sleep[g])
      else $error("sleep request not followed");

    sleep_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && o_in_sleep[g] && st.ctrl[g][BCR_SLP_LSB +: 2] != BCR_SLP_OFF && i_sleep_req[g]
      |=> $stable(o_active_vid[g*7 +: 7]))
      else $error("sleep code not held");

    wake_code_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && !(st.ctrl[g][BCR_SLP_LSB +: 2] != BCR_SLP_OFF && i_sleep_req[g])
      |=> o_active_vid[g*7 +: 7] == $past(i_norm_vid[g*7 +: 7]))
      else $error("normal code not tracked");

    rd_mapped_a: assert property (
      @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && i_rd && hit[g] |=> o_rdata == ($past(st.ctrl[g]) & BCR_CTRL_WMASK))
      else $error("read data differs from register");
  end

  // --------------------------------------------------------------
  // Reset and read port checks
  // --------------------------------------------------------------
  reset_val_a: assert property (
    @(posedge i_sys_clk)
    $past(i_srst) |-> st.ctrl == {BCR_NUM_CONV{BCR_CTRL_RESET}} && o_conv_on == i_pins_on)
    else $error("bad reset value");

  rsv_read_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    i_ce && i_rd |=> (o_rdata & ~BCR_CTRL_WMASK) == 8'h00)
    else $error("top bits read nonzero");

  rd_unmapped_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    i_ce && i_rd && hit == '0 |=> o_rdata == BCR_READ_UNMAPPED)
    else $error("unmapped read not zero");

  rd_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    i_ce && !i_rd |=> $stable(o_rdata))
    else $error("read data changed without a read");

  ce_rdata_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    !i_ce |=> $stable(o_rdata))
    else $error("read data changed while frozen");

  one_hit_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    $onehot0(hit))
    else $error("more than one register selected");

  reset_rdata_a: assert property (
    @(posedge i_sys_clk)
    $past(i_srst) |-> o_rdata == BCR_READ_UNMAPPED)
    else $error("read data not cleared by reset");
endmodule

// file: verification/bcr_host.sv
// Host model: strobe-port register writes and reads
`timescale 1ns/100ps
module bcr_host (
  // Clock
  input wire logic i_sys_clk,
  // Register port
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
  endtask
endmodule

// file: verification/tb_buck_converter_control_regs.sv
// Testbench: register bank reads, writes and converter controls
`timescale 1ns/100ps
module tb_buck_converter_control_regs;
  import bcr_pkg::*;
  logic clk, rst, wr, rd, ce;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] pins, slp, on, fpwm, insl, vval;
  logic [20:0] nvid, svid, avid;
  int bad_count, checks_done;
  bcr_host host (.i_sys_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  bcr_regs dut (.i_sys_clk(clk), .i_srst(rst), .i_ce(ce), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_pins_on(pins), .i_sleep_req(slp),
    .i_norm_vid(nvid), .i_sleep_vid(svid), .o_conv_on(on), .o_fpwm(fpwm),
    .o_in_sleep(insl), .o_vid_valid(vval), .o_active_vid(avid));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a);
    #1 chk(21'(rdata), 21'(exp));
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    pins = 3'h7;
    slp = 3'h0;
    nvid = 21'h0a5432;
    svid = 21'h1b2c3d;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1 chk(21'({on, fpwm, vval}), 21'({3'h7, 3'h0, 3'h7}));
    for (int k = 0; k < 3; k++) begin
      rdchk(BCR_OFS_CONV_A + 8'(k), 8'h0d);
    end
    rdchk(8'h28, 8'h00);
    // Each register: unwritable top bits, mode bit, forced off
    for (int k = 0; k < 3; k++) begin
      host.wr(BCR_OFS_CONV_A + 8'(k), 8'hff);
      #1 chk(21'(fpwm[k]), 21'h1);
      rdchk(BCR_OFS_CONV_A + 8'(k), 8'h3f);
      host.wr(BCR_OFS_CONV_A + 8'(k), 8'h0c);
      #1 chk(21'(on), 21'(3'(3'h7 << (k + 1))));
    end
    // Enabled converter follows the pins
    host.wr(BCR_OFS_CONV_A, 8'h0d);
    pins <= 3'h6;
    #1 chk(21'(on), 21'h0);
    @(posedge clk);
    pins <= 3'h7;
    slp <= 3'h7;
    #1 chk(21'(on), 21'h1);
    // Sleep field values with the sleep pin asserted
    for (int f = 0; f < 4; f++) begin
      host.wr(BCR_OFS_CONV_A, {2'h0, 2'(f), 4'hd});
      @(posedge clk);
      #1 chk(21'({insl[0], avid[6:0]}), 21'(f == 0 ? {1'b0, nvid[6:0]} : {1'b1, svid[6:0]}));
    end
    @(posedge clk);
    svid <= 21'h000001;
    repeat (2) @(posedge clk);
    #1 chk(21'(avid[6:0]), 21'h3d);
    // Reserved field values zero to three
    for (int r = 0; r < 4; r++) begin
      host.wr(BCR_OFS_CONV_C, {4'h0, 2'(r), 2'h1});
      #1 chk(21'(vval[2]), 21'(r == 3));
      rdchk(BCR_OFS_CONV_C, {4'h0, 2'(r), 2'h1});
    end
    // Clock enable low: a write is not taken
    ce <= 1'b0;
    host.wr(BCR_OFS_CONV_A, 8'h0c);
    ce <= 1'b1;
    #1 chk(21'(on[0]), 21'h1);
    rdchk(BCR_OFS_CONV_A, 8'h3d);
    summarize();
  end
endmodule
